// ===== hw/digipot_ctrl.v
// SPI mode 0 slave control logic of a 128-tap digital potentiometer.
// Assumes the SPI pins and power_down_n are asynchronous to core_clk;
// the SPI clock runs far below core_clk so its edges are found by sampling.
`timescale 1ns/10ps
`include "digipot_map.vh"

module digipot_ctrl #(
    parameter NV_WRITE_CYCLES = (`NV_WRITE_MS * 1000000) / `CLK_PERIOD_NS,
    parameter RECALL_CYCLES = (`RECALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter TAPS = 128
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // SPI pins
    input wire sck,
    input wire csN,
    input wire sdi,
    input wire sdoIn,
    output wire sdoOut,
    output wire sdoOeN,
    // Shutdown pin and supply monitor
    input wire powerDownN,
    input wire supplyOk,
    // Non-volatile storage model port
    input wire [6:0] nvStoredValue,
    output reg nvProgram,
    output reg [6:0] nvProgramValue,
    // Potentiometer switch drives and status
    output wire [TAPS-1:0] tapClose,
    output wire arrayOpen,
    output wire wiperGround,
    output reg [6:0] wiperPosition,
    output wire standby
);
    localparam ST_ID = 5'h01;
    localparam ST_INSTR = 5'h02;
    localparam ST_DATA = 5'h04;
    localparam ST_IGNORE = 5'h08;
    localparam ST_DONE = 5'h10;

    localparam PW_PRESET = 3'h1;
    localparam PW_RECALL = 3'h2;
    localparam PW_RUN = 3'h4;

    // Reset value of the access word and end points of the two counters
    localparam [7:0] ACC_INIT = `ACC_RESET;
    localparam [15:0] RECALL_END = RECALL_CYCLES[15:0];
    localparam [31:0] NV_LAST = NV_WRITE_CYCLES - 1;

    // Synchronisers
    reg [1:0] sckSync_q;
    reg [1:0] csSync_q;
    reg [1:0] sdiSync_q;
    reg [1:0] pdSync_q;
    reg [1:0] supSync_q;
    reg sckPrev_q;
    reg csPrev_q;

    // Serial engine
    reg [4:0] state_q;
    reg [2:0] bitCnt_q;
    reg [7:0] shiftIn_q;
    reg [7:0] shiftOut_q;
    reg [3:0] opcode_q;
    reg [1:0] regAddr_q;
    reg armed_q;
    reg sdoLow_q;

    // Registers
    reg [6:0] storedInit_q;
    reg volSel_q;
    reg shdnBit_q;
    reg pendingNv_q;
    reg [6:0] pendingVal_q;
    reg busy_q;
    reg [31:0] nvCnt_q;
    reg [2:0] pwr_q;
    reg [15:0] recallCnt_q;

    wire sckRise;
    wire sckFall;
    wire csFall;
    wire csRise;
    wire selected;
    wire [7:0] byteIn;
    wire [7:0] accessWord;
    wire shutdown;
    wire recallLoad;
    wire byteDone;

    function [7:0] readMux;
        input [1:0] addr;
        input volatile_only_select;
        input [6:0] wiper;
        input [6:0] stored;
        input [7:0] acc;
        begin
            case (addr)
                `ADDR_POSITION: readMux = volatile_only_select ? {1'b0, wiper} : {1'b0, stored};
                `ADDR_ACCESS: readMux = acc;
                default: readMux = 8'h00;
            endcase
        end
    endfunction

    function risingEdge;
        input level;
        input levelPrev;
        begin
            risingEdge = level & ~levelPrev;
        end
    endfunction

    function fallingEdge;
        input level;
        input levelPrev;
        begin
            fallingEdge = ~level & levelPrev;
        end
    endfunction

    // Only the read and write instructions are honoured
    function opKnown;
        input [3:0] op;
        begin
            opKnown = (op == `OP_READ) || (op == `OP_WRITE);
        end
    endfunction

    // Edge strobes last one core cycle and come from the second sync stage
    assign sckRise = risingEdge(sckSync_q[1], sckPrev_q);
    assign sckFall = fallingEdge(sckSync_q[1], sckPrev_q);
    assign csFall = fallingEdge(csSync_q[1], csPrev_q);
    assign csRise = risingEdge(csSync_q[1], csPrev_q);
    assign recallLoad = (pwr_q == PW_RECALL) && (recallCnt_q == RECALL_END);
    assign byteDone = selected & sckRise & (bitCnt_q == 3'h7);
    assign selected = ~csSync_q[1] & armed_q;
    assign byteIn = {shiftIn_q[6:0], sdiSync_q[1]};
    // Access word: the low five bits always read as zero
    assign accessWord = {volSel_q, shdnBit_q, busy_q, 5'h00};
    assign shutdown = ~(pdSync_q[1] & shdnBit_q);
    // Open drain: ones come from the pull-up, the pin is only pulled low
    assign sdoOut = 1'b0;
    assign sdoOeN = ~(sdoLow_q & ~csSync_q[1]);
    // Standby waits for a pending or running stored write to end
    assign standby = csSync_q[1] & ~busy_q & ~pendingNv_q;

    // Pin synchronisers and edge detection on the second stage.
    // Select comes out of reset low, so a select held low through reset
    // never arms the engine; only a real high-to-low transition does.
    always @(posedge core_clk) begin
        if (srst) begin
            sckSync_q <= 2'h0;
            csSync_q <= 2'h0;
            sdiSync_q <= 2'h0;
            pdSync_q <= 2'h0;
            supSync_q <= 2'h0;
            sckPrev_q <= 1'b0;
            csPrev_q <= 1'b0;
        end else begin
            sckSync_q <= {sckSync_q[0], sck};
            csSync_q <= {csSync_q[0], csN};
            sdiSync_q <= {sdiSync_q[0], sdi};
            pdSync_q <= {pdSync_q[0], powerDownN};
            supSync_q <= {supSync_q[0], supplyOk};
            sckPrev_q <= sckSync_q[1];
            csPrev_q <= csSync_q[1];
        end
    end

    // Power-up sequence: preset, then recall from stored value
    always @(posedge core_clk) begin
        if (srst) begin
            pwr_q <= PW_PRESET;
            recallCnt_q <= 16'h0000;
        end else begin
            case (pwr_q)
                PW_PRESET: begin
                    if (supSync_q[1]) begin
                        pwr_q <= PW_RECALL;
                    end
                end
                PW_RECALL: begin
                    recallCnt_q <= recallCnt_q + 16'h0001;
                    // Short settling count before the stored value is trusted
                    if (recallLoad) begin
                        pwr_q <= PW_RUN;
                    end
                end
                PW_RUN: pwr_q <= PW_RUN;
                default: pwr_q <= PW_PRESET;
            endcase
        end
    end

    // Serial engine, register writes and the self-timed stored write
    always @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_ID;
            bitCnt_q <= 3'h0;
            shiftIn_q <= 8'h00;
            opcode_q <= 4'h0;
            regAddr_q <= 2'h0;
            armed_q <= 1'b0;
            wiperPosition <= `WIPER_PRESET;
            storedInit_q <= `INIT_POS_RESET;
            volSel_q <= ACC_INIT[`ACC_VOL_BIT];
            shdnBit_q <= ACC_INIT[`ACC_POWER_DOWN_N_BIT];
            pendingNv_q <= 1'b0;
            pendingVal_q <= 7'h00;
            busy_q <= 1'b0;
            nvCnt_q <= 32'h00000000;
            nvProgram <= 1'b0;
            nvProgramValue <= 7'h00;
        end else begin
            nvProgram <= 1'b0;
            // Power-up recall overrides the preset once the supply is good
            if (recallLoad) begin
                wiperPosition <= nvStoredValue;
                storedInit_q <= nvStoredValue;
            end
            // A new frame always starts from the identification byte
            if (csFall) begin
                armed_q <= 1'b1;
                state_q <= ST_ID;
                bitCnt_q <= 3'h0;
            end
            if (csRise) begin
                state_q <= ST_ID;
                if (pendingNv_q) begin
                    pendingNv_q <= 1'b0;
                    busy_q <= 1'b1;
                    nvCnt_q <= 32'h00000000;
                    nvProgram <= 1'b1;
                    nvProgramValue <= pendingVal_q;
                end
            end
            // Self-timed stored write; host writes are refused until it ends
            if (busy_q) begin
                nvCnt_q <= nvCnt_q + 32'h00000001;
                if (nvCnt_q == NV_LAST) begin
                    busy_q <= 1'b0;
                    storedInit_q <= nvProgramValue;
                end
            end
            if (selected && sckRise) begin
                shiftIn_q <= byteIn;
                bitCnt_q <= bitCnt_q + 3'h1;
                if (byteDone) begin
                    case (state_q)
                        ST_ID: begin
                            state_q <= (byteIn == `ID_BYTE) ? ST_INSTR : ST_IGNORE;
                        end
                        ST_INSTR: begin
                            opcode_q <= byteIn[7:4];
                            regAddr_q <= byteIn[1:0];
                            if (opKnown(byteIn[7:4])) begin
                                state_q <= ST_DATA;
                            end else begin
                                state_q <= ST_IGNORE;
                            end
                        end
                        // Data byte: registers change only when no stored write runs
                        ST_DATA: begin
                            state_q <= ST_DONE;
                            if (opcode_q == `OP_WRITE && !busy_q) begin
                                if (regAddr_q == `ADDR_ACCESS) begin
                                    volSel_q <= byteIn[`ACC_VOL_BIT];
                                    shdnBit_q <= byteIn[`ACC_POWER_DOWN_N_BIT];
                                end else if (regAddr_q == `ADDR_POSITION) begin
                                    wiperPosition <= byteIn[6:0];
                                    if (!volSel_q) begin
                                        pendingNv_q <= 1'b1;
                                        pendingVal_q <= byteIn[6:0];
                                    end
                                end
                            end
                        end
                        default: state_q <= state_q;
                    endcase
                end
            end
        end
    end

    // Read shifter: loads when a known instruction byte completes and moves
    // one bit per falling link clock; a one leaves the line to the pull-up
    always @(posedge core_clk) begin
        if (srst) begin
            shiftOut_q <= 8'h00;
            sdoLow_q <= 1'b0;
        end else if (csRise) begin
            sdoLow_q <= 1'b0;
        end else if (byteDone && state_q == ST_INSTR && opKnown(byteIn[7:4])) begin
            shiftOut_q <= readMux(byteIn[1:0], volSel_q, wiperPosition,
                storedInit_q, accessWord);
        end else if (selected && sckFall) begin
            if (state_q == ST_DATA && opcode_q == `OP_READ) begin
                sdoLow_q <= ~shiftOut_q[7];
                shiftOut_q <= {shiftOut_q[6:0], 1'b0};
            end else begin
                sdoLow_q <= 1'b0;
            end
        end
    end

    // Switch stepping sits in its own module so the tap drives stay registered
    tap_switch #(
        .TAPS(TAPS),
        .WIDTH(7)
    ) u_tap (
        .core_clk(core_clk),
        .srst(srst),
        .tapSel(wiperPosition),
        .shutdown(shutdown),
        .tapClose(tapClose),
        .arrayOpen(arrayOpen),
        .wiperGround(wiperGround)
    );
endmodule

// ===== shared/digipot_map.vh
// Register map, field positions, reset values and timing counts of the
// digital potentiometer control block. Included by the design files.
`ifndef DIGIPOT_MAP_VH
`define DIGIPOT_MAP_VH

// Register addresses carried in the instruction byte
`define ADDR_POSITION 2'h0
`define ADDR_RESERVED 2'h1
`define ADDR_ACCESS 2'h2

// Identification and instruction bytes
`define ID_BYTE 8'h50
`define OP_READ 4'hB
`define OP_WRITE 4'hC

// Access control fields
`define ACC_VOL_BIT 7
`define ACC_POWER_DOWN_N_BIT 6
`define ACC_BUSY_BIT 5
`define ACC_RESET 8'h40

// Wiper reset and limits
`define WIPER_PRESET 7'h40
`define WIPER_MIN 7'h00
`define WIPER_MAX 7'h7F
`define INIT_POS_RESET 7'h40

// Timing
`define CLK_PERIOD_NS 8
`define NV_WRITE_MS 20
`define RECALL_NS 1000

`endif

// ===== hw/tap_switch.v
// Tap selector with make-before-break stepping between two switch states.
// Assumes the select input is already in the core_clk domain.
`timescale 1ns/10ps
`include "digipot_map.vh"
module tap_switch #(
    parameter TAPS = 128,
    parameter WIDTH = 7
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Control
    input wire [WIDTH-1:0] tapSel,
    input wire shutdown,
    // Switch drives
    output reg [TAPS-1:0] tapClose,
    output reg arrayOpen,
    output reg wiperGround
);
    reg [WIDTH-1:0] curTap_q;
    reg [WIDTH-1:0] nextTap_q;
    reg overlap_q;

    always @(posedge core_clk) begin
        if (srst) begin
            curTap_q <= `WIPER_PRESET;
            nextTap_q <= `WIPER_PRESET;
            overlap_q <= 1'b0;
            tapClose <= {TAPS{1'b0}};
            arrayOpen <= 1'b1;
            wiperGround <= 1'b1;
        end else begin
            arrayOpen <= shutdown;
            wiperGround <= shutdown;
            if (shutdown) begin
                tapClose <= {TAPS{1'b0}};
                overlap_q <= 1'b0;
            end else if (overlap_q) begin
                // Second step: old switch opens only now
                tapClose <= {TAPS{1'b0}};
                tapClose[nextTap_q] <= 1'b1;
                curTap_q <= nextTap_q;
                overlap_q <= 1'b0;
            end else if (tapSel != curTap_q || !tapClose[curTap_q]) begin
                // First step: new switch closes while old stays closed
                tapClose[tapSel] <= 1'b1;
                nextTap_q <= tapSel;
                overlap_q <= 1'b1;
            end
        end
    end
endmodule

// ===== sim/digipot_ctrl_props.sv
// Port checker of the pot control block.
// Bound into every digipot_ctrl instance; one clock, sync reset.
`timescale 1ns/10ps
module digipot_ctrl_props #(
    parameter NV_WRITE_CYCLES = 50,
    parameter TAPS = 128
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Watched ports
    input wire csN,
    input wire powerDownN,
    input wire sdoOut,
    input wire sdoOeN,
    input wire nvProgram,
    input wire [TAPS-1:0] tapClose,
    input wire arrayOpen,
    input wire wiperGround,
    input wire [6:0] wiperPosition,
    input wire standby
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire [TAPS-1:0] oneHot = {{(TAPS-1){1'b0}}, 1'b1} << wiperPosition;
    reg [31:0] waitCnt_q;
    // Cycles spent deselected but not yet in standby
    always @(posedge core_clk) begin
        waitCnt_q <= (srst || standby || !csN) ? 32'h0 : waitCnt_q + 32'h1;
    end
    chk_sdo_low: assert property (sdoOut == 1'b0)
        else $error("sdo value not low");
    chk_cs_release: assert property (csN [*6] |-> sdoOeN)
        else $error("sdo driven while deselected");
    chk_sdo_sel: assert property ($fell(sdoOeN) |-> !csN)
        else $error("sdo pulled while deselected");
    chk_shut_pin: assert property (!powerDownN [*6] |->
        arrayOpen && wiperGround && tapClose == 0) else $error("pin shutdown not applied");
    chk_tap_hot: assert property ((!arrayOpen && $stable(wiperPosition)) [*4] |->
        tapClose == oneHot) else $error("tap does not follow wiper");
    chk_make_break: assert property (!arrayOpen && $past(tapClose) != 0 && tapClose != 0 |->
        (tapClose & $past(tapClose)) != 0) else $error("tap broken before make");
    chk_nv_start: assert property (nvProgram |-> csN ##1 !nvProgram)
        else $error("stored write start wrong");
    chk_nv_busy: assert property (nvProgram |=> !standby [*8])
        else $error("standby during stored write");
    chk_nv_bound: assert property (waitCnt_q <= NV_WRITE_CYCLES + 16)
        else $error("stored write too long");
    chk_wiper_preset: assert property ($fell(srst) |-> wiperPosition == 7'h40)
        else $error("wiper preset wrong");
    chk_sel_active: assert property (!csN [*4] |-> !standby)
        else $error("standby while selected");
    cov_nv: cover property (nvProgram);
    cov_shut: cover property ($rose(arrayOpen));
    cov_read: cover property ($fell(sdoOeN));
endmodule
bind digipot_ctrl digipot_ctrl_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES), .TAPS(TAPS)) chk (
    .core_clk(core_clk), .srst(srst), .csN(csN), .powerDownN(powerDownN),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN), .nvProgram(nvProgram), .tapClose(tapClose),
    .arrayOpen(arrayOpen), .wiperGround(wiperGround), .wiperPosition(wiperPosition),
    .standby(standby));

// ===== sim/spi_host_model.sv
// SPI mode 0 host: 24-bit frames, sck period ten core cycles.
// Changes its pins at the falling core clock edge only.
`timescale 1ns/10ps
module spi_host_model (
    // Clock
    input wire core_clk,
    // SPI wires
    input wire sdoWire,
    output reg sck,
    output reg csN,
    output reg sdi
);
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end
    task half;
        repeat (5) @(negedge core_clk);
    endtask
    task xfer(input [23:0] tx, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            @(negedge core_clk);
            csN = 1'b0;
            half;
            for (i = 23; i >= 0; i = i - 1) begin
                sdi = tx[i];
                half;
                if (i < 8) rx = {rx[6:0], sdoWire};
                sck = 1'b1;
                half;
                sck = 1'b0;
            end
            half;
            csN = 1'b1;
            // Released data line shows the inverse of its last bit
            sdi = ~sdi;
            repeat (30) @(negedge core_clk);
        end
    endtask
endmodule

// ===== sim/spi_digital_pot_control_test.sv
// Self-checking bench of the pot control block with a host model.
// Bench holds the stored-value memory; reset is synchronous.
`timescale 1ns/10ps
`include "digipot_map.vh"
module spi_digital_pot_control_test;
    localparam TAPS = 128;
    reg core_clk = 1'b0;
    reg srst = 1'b1;
    reg powerDownN = 1'b1;
    reg supplyOk = 1'b0;
    reg [6:0] nvMem = 7'h00;
    wire sck, csN, sdi, sdoOut, sdoOeN, nvProgram, arrayOpen, wiperGround, standby;
    wire [6:0] nvProgramValue, wiperPosition;
    wire [TAPS-1:0] tapClose;
    // Pull-up on the open-drain line
    wire sdoWire = sdoOeN ? 1'b1 : sdoOut;
    integer err_total = 0;
    integer check_count = 0;
    integer i;
    reg [7:0] rd;
    reg [6:0] val, held;
    always #4 core_clk = ~core_clk;
    always @(negedge core_clk) if (nvProgram === 1'b1) nvMem <= nvProgramValue;
    spi_host_model host (.core_clk(core_clk), .sdoWire(sdoWire), .sck(sck), .csN(csN), .sdi(sdi));
    digipot_ctrl #(.NV_WRITE_CYCLES(2000), .RECALL_CYCLES(4), .TAPS(TAPS)) dut (
        .core_clk(core_clk), .srst(srst), .sck(sck), .csN(csN), .sdi(sdi), .sdoIn(sdoWire),
        .sdoOut(sdoOut), .sdoOeN(sdoOeN), .powerDownN(powerDownN), .supplyOk(supplyOk),
        .nvStoredValue(nvMem), .nvProgram(nvProgram), .nvProgramValue(nvProgramValue),
        .tapClose(tapClose), .arrayOpen(arrayOpen), .wiperGround(wiperGround),
        .wiperPosition(wiperPosition), .standby(standby));
    function [TAPS-1:0] tapOf(input [6:0] w);
        tapOf = {{(TAPS-1){1'b0}}, 1'b1} << w;
    endfunction
    task cmp8(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task cmpTap(input [TAPS-1:0] got, input [TAPS-1:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [1:0] a, input [7:0] d);
        host.xfer({`ID_BYTE, `OP_WRITE, 2'h0, a, d}, rd);
    endtask
    task rdReg(input [1:0] a, output [7:0] d);
        host.xfer({`ID_BYTE, `OP_READ, 2'h0, a, 8'h00}, d);
    endtask
    task finish_test;
        begin
            $display("checks %0d, mismatches %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task powerUp;
        begin
            srst = 1'b1;
            supplyOk = 1'b0;
            repeat (3) @(negedge core_clk);
            srst = 1'b0;
            repeat (8) @(negedge core_clk);
            cmp8({1'b0, wiperPosition}, 8'h40);
            supplyOk = 1'b1;
            repeat (20) @(negedge core_clk);
            cmp8({1'b0, wiperPosition}, {1'b0, nvMem});
            $display("power-up test ended");
        end
    endtask
    initial begin
        #700000;
        err_total = err_total + 1;
        finish_test;
    end
    initial begin
        val = 7'($urandom(32'h653D94ED));
        nvMem = 7'($urandom);
        powerUp;
        wr(2'h2, 8'hC0);
        rdReg(2'h2, rd);
        cmp8(rd, 8'hC0);
        for (i = 0; i < 6; i = i + 1) begin
            val = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
            wr(2'h0, {1'b0, val});
            cmpTap(tapClose, tapOf(val));
            rdReg(2'h0, rd);
            cmp8(rd, {1'b0, val});
        end
        $display("volatile test ended");
        held = val;
        for (i = 0; i < 4; i = i + 1) begin
            wr(2'h2, {1'b1, i[0], 6'h00});
            powerDownN = i[1];
            repeat (8) @(negedge core_clk);
            rdReg(2'h0, rd);
            cmp8(rd, {1'b0, held});
            cmp8({6'h00, arrayOpen, wiperGround}, (i == 3) ? 8'h00 : 8'h03);
            cmpTap(tapClose, (i == 3) ? tapOf(held) : {TAPS{1'b0}});
        end
        $display("shutdown test ended");
        wr(2'h2, 8'h40);
        val = 7'($urandom);
        wr(2'h0, {1'b0, val});
        cmp8({1'b0, wiperPosition}, {1'b0, val});
        cmp8({7'h00, standby}, 8'h00);
        rdReg(2'h2, rd);
        cmp8(rd, 8'h60);
        wr(2'h0, {1'b0, ~val});
        cmp8({1'b0, wiperPosition}, {1'b0, val});
        i = 0;
        while (standby !== 1'b1 && i < 3000) begin
            @(negedge core_clk);
            i = i + 1;
        end
        if (i == 3000) begin
            err_total = err_total + 1;
        end
        cmp8({1'b0, nvMem}, {1'b0, val});
        wr(2'h2, 8'hC0);
        wr(2'h0, {1'b0, ~val});
        wr(2'h2, 8'h40);
        rdReg(2'h0, rd);
        cmp8(rd, {1'b0, val});
        rdReg(2'h2, rd);
        cmp8(rd, 8'h40);
        $display("stored write test ended");
        for (i = 0; i < 4; i = i + 1) begin
            host.xfer({(i == 0) ? 16'h51C0 : (i == 1) ? 16'h50D0 : (i == 2) ? 16'h50C1 : 16'h51B0,
                8'h00}, rd);
            cmp8(rd, 8'hFF);
            cmp8({1'b0, wiperPosition}, {1'b0, ~val});
        end
        rdReg(2'h1, rd);
        cmp8(rd, 8'h00);
        $display("refusal test ended");
        powerUp;
        finish_test;
    end
endmodule
